/* src/ebie_cfg.svh */
`ifndef EBIE_CFG_SVH
`define EBIE_CFG_SVH

// Wishbone byte offsets
`define EBIE_OFS_INSTR    10'h000
`define EBIE_OFS_STATUS   10'h004
`define EBIE_OFS_PC       10'h008
`define EBIE_OFS_SP       10'h00c
// adr[9:7] window selects: general registers 0x100, low I/O 0x180
`define EBIE_WIN_GPR      3'h2
`define EBIE_WIN_IO       3'h3

// Status flag bit positions
`define EBIE_FLAG_C       3'h0
`define EBIE_FLAG_Z       3'h1
`define EBIE_FLAG_N       3'h2
`define EBIE_FLAG_V       3'h3
`define EBIE_FLAG_S       3'h4
`define EBIE_FLAG_H       3'h5
`define EBIE_FLAG_T       3'h6
`define EBIE_FLAG_I       3'h7
// Status register: sticky unsupported-instruction bit
`define EBIE_STAT_BAD_BIT 5'h08

// Low I/O range and the register holding write-one-to-clear flags
`define EBIE_IO_HIGH_BIT  3'h5
`define EBIE_W1C_ADDR     5'h0e
`define EBIE_W1C_MASK     8'hc0

// Z pointer pair and reset values
`define EBIE_PAIR_Z       4'hf
`define EBIE_PC_RESET     16'h0000
`define EBIE_SP_RESET     4'h0

// Execution times in core cycles
`define EBIE_CYC_ONE      3'h1
`define EBIE_CYC_TWO      3'h2
`define EBIE_CYC_THREE    3'h3
`define EBIE_CYC_FOUR     3'h4

`endif

/* src/ebie_pkg.sv */
package ebie_pkg;

  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMMEDIATE, OP_SUB,
    OP_SUBTRACT_CONST, OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_BORROW_CONST,
    OP_WORD_SUB_IMMEDIATE, OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST,
    OP_XOR_REGS, OP_BITWISE_INVERT, OP_ARITH_INVERT_PLUS_ONE,
    OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_INC, OP_MINUS_ONE,
    OP_ZERO_SIGN_CHECK, OP_ZERO_REGISTER, OP_FILL_ONES, OP_RELATIVE_JUMP,
    OP_INDIRECT_JUMP, OP_RELATIVE_CALL, OP_INDIRECT_CALL,
    OP_SUBROUTINE_BACK, OP_INTERRUPT_BACK, OP_SKIP_IF_EQUAL,
    OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH, OP_SKIP_IO_BIT_LOW,
    OP_SKIP_IO_BIT_HIGH, OP_BRANCH_FLAG_HIGH, OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR
  } ebie_op_t;

  typedef enum logic {
    EBIE_IDLE,
    EBIE_EXEC
  } ebie_fsm_t;

  typedef struct packed {
    logic        next_long;
    logic [11:0] k;
    logic [4:0]  rr;
    logic [4:0]  rd;
    ebie_op_t    op;
  } ebie_instr_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] dat;
  } ebie_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ebie_wb_rsp_t;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       h;
    logic       v;
  } ebie_alu_t;

  typedef struct packed {
    logic [31:0][7:0]  gpr;
    logic [31:0][7:0]  io;
    logic [15:0][15:0] stack;
    ebie_instr_t       last;
    logic [15:0]       pc;
    logic [3:0]        sp;
    logic [7:0]        flags;
    logic              bad;
    ebie_fsm_t         fsm;
    logic [2:0]        cnt;
    logic              busy;
    ebie_wb_rsp_t      rsp;
  } ebie_state_t;

endpackage : ebie_pkg

/* src/ebie_core.sv */
// What this block does
// - Bit set, clear and skip work on I/O 0x00-0x1F only.
// - Some I/O status flags clear when software writes one to them.
// - Single-bit I/O set or clear changes only that bit.
// - Register add, with or without carry: one cycle, flags Z C N V H.
// - Word immediate add or subtract: two cycles, flags Z C N V S.
// - Subtract register or constant, with or without carry: one cycle.
// - AND, OR, XOR forms: one cycle, flags Z N V only.
// - Invert gives 0xFF minus value, flags Z C N V.
// - Negate gives 0x00 minus value, flags Z C N V H.
// - Increment and decrement: one cycle, Z N V, carry untouched.
// - Relative jump: PC plus offset plus one, two cycles.
// - Indirect jump and call load PC from Z: two and three cycles.
// - Relative call saves return address, jumps, takes three cycles.
// - Skip if equal passes next instruction, 1, 2 or 3 cycles.
// - Compares set Z N V C H, store nothing, one cycle.
// - Skip on general register bit low or high, 1, 2 or 3 cycles.
// - Skip on low I/O bit low or high, 1, 2 or 3 cycles.
// - Branch on flag high: offset plus one, two cycles, else one.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ebie_cfg.svh"

module ebie_core (
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  RST_IN,
  input  wire ebie_pkg::ebie_wb_req_t WB_REQ_IN,
  input  wire logic [7:0]            IO_FLAG_SET_IN,
  output ebie_pkg::ebie_wb_rsp_t     WB_RSP_OUT,
  output logic                       GIE_OUT,
  output logic                       BUSY_OUT
);
  import ebie_pkg::*;
  ebie_state_t s_reg;
  ebie_state_t s_next;
  function automatic ebie_alu_t add8(input logic [7:0] a, b,
                                     input logic       ci);
    ebie_alu_t  o;
    logic [8:0] sum;
    sum   = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    o.res = sum[7:0];
    o.c   = sum[8];
    o.h   = (a[3] & b[3]) | (b[3] & ~o.res[3]) | (~o.res[3] & a[3]);
    o.v   = (a[7] & b[7] & ~o.res[7]) | (~a[7] & ~b[7] & o.res[7]);
    return o;
  endfunction : add8
  function automatic ebie_alu_t sub8(input logic [7:0] a, b,
                                     input logic       ci);
    ebie_alu_t  o;
    logic [8:0] dif;
    dif   = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    o.res = dif[7:0];
    o.c   = dif[8];
    o.h   = (~a[3] & b[3]) | (b[3] & o.res[3]) | (o.res[3] & ~a[3]);
    o.v   = (a[7] & ~b[7] & ~o.res[7]) | (~a[7] & b[7] & o.res[7]);
    return o;
  endfunction : sub8
  // Z C N V H; borrow forms keep Z only if it was already set
  function automatic logic [7:0] put_arith(input logic [7:0] f,
                                           input ebie_alu_t  a,
                                           input logic       keep_z);
    logic [7:0] o;
    o                = f;
    o[`EBIE_FLAG_Z]  = (a.res == 8'h00) & (~keep_z | f[`EBIE_FLAG_Z]);
    o[`EBIE_FLAG_C]  = a.c;
    o[`EBIE_FLAG_N]  = a.res[7];
    o[`EBIE_FLAG_V]  = a.v;
    o[`EBIE_FLAG_H]  = a.h;
    return o;
  endfunction : put_arith
  function automatic logic [7:0] put_logic(input logic [7:0] f, r,
                                           input logic       v);
    logic [7:0] o;
    o               = f;
    o[`EBIE_FLAG_Z] = (r == 8'h00);
    o[`EBIE_FLAG_N] = r[7];
    o[`EBIE_FLAG_V] = v;
    return o;
  endfunction : put_logic
  function automatic logic [15:0] pc_rel(input logic [15:0] pc,
                                         input logic [11:0] k);
    return pc + {{4{k[11]}}, k} + 16'h0001;
  endfunction : pc_rel
  always_comb
  begin
    ebie_instr_t ins;
    ebie_alu_t   a;
    logic [7:0]  rdv, rrv, imm, r8, wmask;
    logic [15:0] w, wr, zp;
    logic [2:0]  cyc_n;
    logic        cond, skip, wr_ok;
    ins    = ebie_instr_t'(WB_REQ_IN.dat[28:0]);
    a      = '0;
    rdv    = s_reg.gpr[ins.rd];
    rrv    = s_reg.gpr[ins.rr];
    imm    = ins.k[7:0];
    r8     = 8'h00;
    wmask  = 8'h00;
    w      = {s_reg.gpr[{ins.rd[4:1], 1'b1}], s_reg.gpr[{ins.rd[4:1], 1'b0}]};
    wr     = 16'h0000;
    zp     = {s_reg.gpr[{`EBIE_PAIR_Z, 1'b1}], s_reg.gpr[{`EBIE_PAIR_Z, 1'b0}]};
    cyc_n  = `EBIE_CYC_ONE;
    cond   = 1'b0;
    skip   = 1'b0;
    wr_ok  = WB_REQ_IN.we & WB_REQ_IN.sel[0];
    s_next = s_reg;
    s_next.rsp.ack = 1'b0;
    s_next.rsp.dat = 32'h0000_0000;
    case (s_reg.fsm)
      EBIE_IDLE:
      begin
        if (WB_REQ_IN.cyc && WB_REQ_IN.stb && !s_reg.rsp.ack)
        begin
          if (WB_REQ_IN.we && WB_REQ_IN.adr == `EBIE_OFS_INSTR)
          begin
            s_next.last = ins;
            s_next.pc   = s_reg.pc + 16'h0001;
            case (ins.op)
              OP_ADD, OP_ADD_CARRY:
              begin
                a = add8(rdv, rrv, (ins.op == OP_ADD_CARRY) &
                                   s_reg.flags[`EBIE_FLAG_C]);
                s_next.gpr[ins.rd] = a.res;
                s_next.flags = put_arith(s_reg.flags, a, 1'b0);
              end
              OP_SUB, OP_SUBTRACT_CONST, OP_SUBTRACT_WITH_BORROW,
              OP_SUBTRACT_BORROW_CONST, OP_COMPARE_REGS,
              OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE:
              begin
                cond = ins.op inside {OP_SUBTRACT_WITH_BORROW,
                                      OP_SUBTRACT_BORROW_CONST,
                                      OP_COMPARE_REGS_CARRY};
                a = sub8(rdv,
                         (ins.op inside {OP_SUBTRACT_CONST,
                                         OP_SUBTRACT_BORROW_CONST,
                                         OP_COMPARE_IMMEDIATE}) ? imm : rrv,
                         cond & s_reg.flags[`EBIE_FLAG_C]);
                s_next.flags = put_arith(s_reg.flags, a, cond);
                if (!(ins.op inside {OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY,
                                     OP_COMPARE_IMMEDIATE}))
                  s_next.gpr[ins.rd] = a.res;
              end
              OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST, OP_XOR_REGS,
              OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_SIGN_CHECK,
              OP_ZERO_REGISTER:
              begin
                case (ins.op)
                  OP_AND:             r8 = rdv & rrv;
                  OP_AND_CONST:       r8 = rdv & imm;
                  OP_OR:              r8 = rdv | rrv;
                  OP_OR_CONST,
                  OP_SET_BITS_MASK:   r8 = rdv | imm;
                  OP_XOR_REGS:        r8 = rdv ^ rrv;
                  OP_CLEAR_BITS_MASK: r8 = rdv & (8'hff - imm);
                  OP_ZERO_SIGN_CHECK: r8 = rdv & rdv;
                  default:            r8 = rdv ^ rdv;
                endcase
                s_next.gpr[ins.rd] = r8;
                s_next.flags = put_logic(s_reg.flags, r8, 1'b0);
              end
              OP_BITWISE_INVERT:
              begin
                r8 = 8'hff - rdv;
                s_next.gpr[ins.rd] = r8;
                s_next.flags = put_logic(s_reg.flags, r8, 1'b0);
                s_next.flags[`EBIE_FLAG_C] = 1'b1;
              end
              OP_ARITH_INVERT_PLUS_ONE:
              begin
                a = sub8(8'h00, rdv, 1'b0);
                s_next.gpr[ins.rd] = a.res;
                s_next.flags = put_arith(s_reg.flags, a, 1'b0);
              end
              OP_INC, OP_MINUS_ONE:
              begin
                r8 = (ins.op == OP_INC) ? rdv + 8'h01 : rdv - 8'h01;
                s_next.gpr[ins.rd] = r8;
                s_next.flags = put_logic(s_reg.flags, r8,
                  (ins.op == OP_INC) ? (r8 == 8'h80) : (r8 == 8'h7f));
              end
              OP_FILL_ONES:
                s_next.gpr[ins.rd] = 8'hff;
              OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE:
              begin
                cyc_n = `EBIE_CYC_TWO;
                cond  = (ins.op == OP_WORD_ADD_IMMEDIATE);
                wr    = cond ? w + {10'h000, ins.k[5:0]}
                             : w - {10'h000, ins.k[5:0]};
                s_next.gpr[{ins.rd[4:1], 1'b0}] = wr[7:0];
                s_next.gpr[{ins.rd[4:1], 1'b1}] = wr[15:8];
                s_next.flags[`EBIE_FLAG_Z] = (wr == 16'h0000);
                s_next.flags[`EBIE_FLAG_N] = wr[15];
                s_next.flags[`EBIE_FLAG_C] = cond ? (~wr[15] & w[15])
                                                  : (wr[15] & ~w[15]);
                s_next.flags[`EBIE_FLAG_V] = cond ? (~w[15] & wr[15])
                                                  : (w[15] & ~wr[15]);
                s_next.flags[`EBIE_FLAG_S] = wr[15] ^
                                             s_next.flags[`EBIE_FLAG_V];
              end
              OP_RELATIVE_JUMP:
              begin
                cyc_n     = `EBIE_CYC_TWO;
                s_next.pc = pc_rel(s_reg.pc, ins.k);
              end
              OP_INDIRECT_JUMP:
              begin
                cyc_n     = `EBIE_CYC_TWO;
                s_next.pc = zp;
              end
              OP_RELATIVE_CALL, OP_INDIRECT_CALL:
              begin
                cyc_n = `EBIE_CYC_THREE;
                // Stack of 16 return addresses wraps silently when overrun
                s_next.stack[s_reg.sp] = s_reg.pc + 16'h0001;
                s_next.sp = s_reg.sp + 4'h1;
                s_next.pc = (ins.op == OP_INDIRECT_CALL) ? zp
                          : pc_rel(s_reg.pc, ins.k);
              end
              OP_SUBROUTINE_BACK, OP_INTERRUPT_BACK:
              begin
                cyc_n     = `EBIE_CYC_FOUR;
                s_next.sp = s_reg.sp - 4'h1;
                s_next.pc = s_reg.stack[s_reg.sp - 4'h1];
                if (ins.op == OP_INTERRUPT_BACK)
                  s_next.flags[`EBIE_FLAG_I] = 1'b1;
              end
              OP_SKIP_IF_EQUAL:
                skip = (rdv == rrv);
              OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH:
                skip = rdv[ins.rr[2:0]] ==
                       (ins.op == OP_SKIP_REG_BIT_HIGH);
              OP_SKIP_IO_BIT_LOW, OP_SKIP_IO_BIT_HIGH,
              OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
              begin
                // Above the low range these do nothing but flag it
                if (ins.k[`EBIE_IO_HIGH_BIT] || ins.k[11:6] != 6'h00)
                  s_next.bad = 1'b1;
                else if (ins.op == OP_SKIP_IO_BIT_LOW ||
                         ins.op == OP_SKIP_IO_BIT_HIGH)
                  skip = s_reg.io[ins.k[4:0]][ins.rr[2:0]] ==
                         (ins.op == OP_SKIP_IO_BIT_HIGH);
                else
                begin
                  cyc_n = `EBIE_CYC_TWO;
                  // Sibling write-one-to-clear flags stay as they are
                  s_next.io[ins.k[4:0]][ins.rr[2:0]] =
                    (ins.op == OP_IO_BIT_SET);
                end
              end
              OP_BRANCH_FLAG_HIGH:
              begin
                if (s_reg.flags[ins.rr[2:0]])
                begin
                  cyc_n     = `EBIE_CYC_TWO;
                  s_next.pc = pc_rel(s_reg.pc, ins.k);
                end
              end
              default:
                s_next.bad = 1'b1;
            endcase
            if (skip)
            begin
              cyc_n     = ins.next_long ? `EBIE_CYC_THREE
                                        : `EBIE_CYC_TWO;
              s_next.pc = s_reg.pc + (ins.next_long ? 16'h0003 : 16'h0002);
            end
            if (cyc_n == `EBIE_CYC_ONE)
              s_next.rsp.ack = 1'b1;
            else
            begin
              s_next.fsm = EBIE_EXEC;
              s_next.cnt = cyc_n - 3'h1;
            end
          end
          else
          begin
            s_next.rsp.ack = 1'b1;
            if (WB_REQ_IN.adr[9:7] == `EBIE_WIN_GPR)
            begin
              s_next.rsp.dat = {24'h000000, s_reg.gpr[WB_REQ_IN.adr[6:2]]};
              if (wr_ok)
                s_next.gpr[WB_REQ_IN.adr[6:2]] = WB_REQ_IN.dat[7:0];
            end
            else if (WB_REQ_IN.adr[9:7] == `EBIE_WIN_IO)
            begin
              s_next.rsp.dat = {24'h000000, s_reg.io[WB_REQ_IN.adr[6:2]]};
              wmask = (WB_REQ_IN.adr[6:2] == `EBIE_W1C_ADDR) ?
                      `EBIE_W1C_MASK : 8'h00;
              if (wr_ok)
                s_next.io[WB_REQ_IN.adr[6:2]] =
                  (WB_REQ_IN.dat[7:0] & ~wmask) |
                  (s_reg.io[WB_REQ_IN.adr[6:2]] & wmask &
                   ~WB_REQ_IN.dat[7:0]);
            end
            else
            begin
              case (WB_REQ_IN.adr)
                `EBIE_OFS_INSTR:
                  s_next.rsp.dat = {3'h0, s_reg.last};
                `EBIE_OFS_STATUS:
                begin
                  s_next.rsp.dat = {23'h000000, s_reg.bad, s_reg.flags};
                  if (wr_ok)
                    s_next.flags = WB_REQ_IN.dat[7:0];
                  if (WB_REQ_IN.we && WB_REQ_IN.sel[1] &&
                      WB_REQ_IN.dat[`EBIE_STAT_BAD_BIT])
                    s_next.bad = 1'b0;
                end
                `EBIE_OFS_PC:
                begin
                  s_next.rsp.dat = {16'h0000, s_reg.pc};
                  if (wr_ok)
                    s_next.pc[7:0] = WB_REQ_IN.dat[7:0];
                  if (WB_REQ_IN.we && WB_REQ_IN.sel[1])
                    s_next.pc[15:8] = WB_REQ_IN.dat[15:8];
                end
                `EBIE_OFS_SP:
                begin
                  s_next.rsp.dat = {28'h0000000, s_reg.sp};
                  if (wr_ok)
                    s_next.sp = WB_REQ_IN.dat[3:0];
                end
                default:
                  s_next.rsp.dat = 32'h0000_0000;
              endcase
            end
          end
        end
      end
      EBIE_EXEC:
      begin
        // Bus stays stalled until the instruction's cycle count is spent
        if (s_reg.cnt == 3'h1)
        begin
          s_next.rsp.ack = 1'b1;
          s_next.fsm     = EBIE_IDLE;
          s_next.cnt     = 3'h0;
        end
        else
          s_next.cnt = s_reg.cnt - 3'h1;
      end
      default:
        s_next.fsm = EBIE_IDLE;
    endcase
    // Hardware set wins over a same-cycle software clear
    s_next.io[`EBIE_W1C_ADDR] = s_next.io[`EBIE_W1C_ADDR] |
                                (IO_FLAG_SET_IN & `EBIE_W1C_MASK);
    s_next.busy = (s_next.fsm == EBIE_EXEC);
  end
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      s_reg    <= '0;
      s_reg.pc <= `EBIE_PC_RESET;
      s_reg.sp <= `EBIE_SP_RESET;
    end
    else
      s_reg <= s_next;
  end
  assign WB_RSP_OUT = s_reg.rsp;
  assign GIE_OUT    = s_reg.flags[`EBIE_FLAG_I];
  assign BUSY_OUT   = s_reg.busy;

endmodule : ebie_core

/* verification/ebie_core_checker.sv */
`timescale 1ns/100ps
module ebie_core_checker (
  input wire logic                   CLK_SYS_IN,
  input wire logic                   RST_IN,
  input wire ebie_pkg::ebie_wb_req_t WB_REQ_IN,
  input wire logic [7:0]             IO_FLAG_SET_IN,
  input wire ebie_pkg::ebie_wb_rsp_t WB_RSP_OUT,
  input wire logic                   GIE_OUT,
  input wire logic                   BUSY_OUT
);
  import ebie_pkg::*;
  logic       ack;
  logic [5:0] op;
  assign ack = WB_RSP_OUT.ack;
  assign op  = WB_REQ_IN.dat[5:0];
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);
  // Master leaves a gap, so a rising strobe marks the taking edge
  sequence s_take;
    $rose(WB_REQ_IN.stb);
  endsequence
  sequence s_instr;
    s_take ##0 (WB_REQ_IN.we && WB_REQ_IN.adr == 10'h000);
  endsequence
  sequence s_hold;
    BUSY_OUT && !ack;
  endsequence
  sequence s_done;
    ack && !BUSY_OUT;
  endsequence
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack held beyond one cycle");
  a_idle_data: assert property (!ack |-> WB_RSP_OUT.dat == 32'h0)
    else $error("data driven outside ack");
  a_reg_single: assert property (
    s_take ##0 (WB_REQ_IN.adr != 10'h000) |=> s_done)
    else $error("register access not answered next cycle");
  a_alu_single: assert property (
    s_instr ##0 (op inside {0, 1, [3:6], [8:21], [29:31]}) |=> s_done)
    else $error("one cycle operation took longer");
  a_word_double: assert property (
    s_instr ##0 (op inside {2, 7, 22, 23}) |=> s_hold ##1 s_done)
    else $error("two cycle operation mistimed");
  a_call_triple: assert property (
    s_instr ##0 (op inside {24, 25}) |=> s_hold[*2] ##1 s_done)
    else $error("call mistimed");
  a_return_quad: assert property (
    s_instr ##0 (op inside {26, 27}) |=> s_hold[*3] ##1 s_done)
    else $error("return mistimed");
  a_skip_bound: assert property (
    s_instr ##0 (op inside {28, [32:35]}) |=>
      s_done or (s_hold ##1 s_done) or (s_hold[*2] ##1 s_done))
    else $error("skip outside one to three cycles");
  a_branch_bound: assert property (
    s_instr ##0 (op == 6'd36) |=> s_done or (s_hold ##1 s_done))
    else $error("branch outside one or two cycles");
  a_gie_cause: assert property (
    $changed(GIE_OUT) |-> $past(WB_REQ_IN.cyc) || $past(WB_REQ_IN.cyc, 2))
    else $error("interrupt enable moved without a request");
endmodule : ebie_core_checker

bind ebie_core ebie_core_checker chk_u (
  .CLK_SYS_IN(CLK_SYS_IN),
  .RST_IN(RST_IN),
  .WB_REQ_IN(WB_REQ_IN),
  .IO_FLAG_SET_IN(IO_FLAG_SET_IN),
  .WB_RSP_OUT(WB_RSP_OUT),
  .GIE_OUT(GIE_OUT),
  .BUSY_OUT(BUSY_OUT)
);

/* verification/ebie_core_tb.sv */
`timescale 1ns/100ps
`include "ebie_cfg.svh"
module ebie_core_tb;
  import ebie_pkg::*;
  localparam logic [9:0] st_a = `EBIE_OFS_STATUS;
  localparam logic [9:0] pc_a = `EBIE_OFS_PC;
  localparam logic [9:0] sp_a = `EBIE_OFS_SP;
  logic         clk  = 1'b0;
  logic         rst  = 1'b1;
  ebie_wb_req_t req  = '0;
  logic [7:0]   fset = 8'h00;
  ebie_wb_rsp_t rsp;
  logic         gie;
  logic         busy;
  logic [31:0]  rdat;
  int           ncyc;
  int           fails = 0;
  int           samples_checked = 0;

  always #5 clk = ~clk;

  ebie_core dut_u (
    .CLK_SYS_IN(clk),
    .RST_IN(rst),
    .WB_REQ_IN(req),
    .IO_FLAG_SET_IN(fset),
    .WB_RSP_OUT(rsp),
    .GIE_OUT(gie),
    .BUSY_OUT(busy)
  );

  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; ncyc ends one above the run time
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
    req  <= '{1'b1, 1'b1, w, 4'hf, a, d};
    ncyc = 0;
    do
    begin
      @(posedge clk);
      ncyc++;
    end
    while (rsp.ack !== 1'b1 && ncyc < 20);
    if (rsp.ack !== 1'b1)
    begin
      fails++;
      give_verdict();
    end
    rdat = rsp.dat;
    req  <= '0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd

  task automatic run(input logic [31:0] i, input int n);
    xfer(1'b1, `EBIE_OFS_INSTR, i);
    chk(32'(ncyc - 1), 32'(n));
  endtask : run

  task automatic sk(input logic [31:0] i, input int n);
    wr(pc_a, 32'h20);
    run(i, n);
    rd(pc_a, 32'(32'h20 + n));
  endtask : sk

  function automatic logic [9:0] ga(input int n);
    return 10'h100 + 10'(4 * n);
  endfunction : ga

  function automatic logic [9:0] ia(input int n);
    return 10'h180 + 10'(4 * n);
  endfunction : ia

  function automatic logic [31:0] ins(input logic [5:0] op,
    input logic [4:0] d, input logic [4:0] r, input logic [11:0] k,
    input logic nl = 1'b0);
    return {3'h0, nl, k, r, d, op};
  endfunction : ins

  // Constant forms take b as their immediate, so r2 must stay b
  task automatic alu(input logic [5:0] op, input logic [7:0] a, b,
                     input logic [7:0] fi, res, fo);
    wr(ga(1), {24'h0, a});
    wr(ga(2), {24'h0, b});
    wr(st_a, {24'h0, fi});
    run(ins(op, 5'd1, 5'd2, {4'h0, b}), 1);
    rd(ga(1), {24'h0, res});
    rd(ga(2), {24'h0, b});
    rd(st_a, {24'h0, fo});
  endtask : alu

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(pc_a, 32'h0);
    rd(st_a, 32'h0);
    rd(10'h050, 32'h0);
    alu(6'd0, 8'h0f, 8'h01, 8'h00, 8'h10, 8'h20);
    alu(6'd1, 8'h7f, 8'h00, 8'h01, 8'h80, 8'h2c);
    alu(6'd3, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h20);
    alu(6'd4, 8'h00, 8'h01, 8'h00, 8'hff, 8'h25);
    alu(6'd5, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h28);
    alu(6'd6, 8'h00, 8'h00, 8'h03, 8'hff, 8'h25);
    alu(6'd8, 8'hf0, 8'h0f, 8'h21, 8'h00, 8'h23);
    alu(6'd9, 8'h3c, 8'hf0, 8'h00, 8'h30, 8'h00);
    alu(6'd10, 8'h01, 8'h02, 8'h00, 8'h03, 8'h00);
    alu(6'd11, 8'h80, 8'h01, 8'h09, 8'h81, 8'h05);
    alu(6'd12, 8'haa, 8'haa, 8'h00, 8'h00, 8'h02);
    alu(6'd13, 8'h55, 8'h00, 8'h20, 8'haa, 8'h25);
    alu(6'd14, 8'h01, 8'h00, 8'h00, 8'hff, 8'h25);
    alu(6'd15, 8'h00, 8'h80, 8'h00, 8'h80, 8'h04);
    alu(6'd16, 8'hff, 8'h0f, 8'h00, 8'hf0, 8'h04);
    alu(6'd17, 8'h7f, 8'h00, 8'h01, 8'h80, 8'h0d);
    alu(6'd18, 8'h01, 8'h00, 8'h01, 8'h00, 8'h03);
    alu(6'd19, 8'h80, 8'h00, 8'h00, 8'h80, 8'h04);
    alu(6'd20, 8'h33, 8'h00, 8'h00, 8'h00, 8'h02);
    alu(6'd21, 8'h12, 8'h00, 8'h3f, 8'hff, 8'h3f);
    alu(6'd29, 8'h01, 8'h02, 8'h00, 8'h01, 8'h25);
    alu(6'd30, 8'h05, 8'h05, 8'h03, 8'h05, 8'h25);
    alu(6'd31, 8'h05, 8'h05, 8'h00, 8'h05, 8'h02);
    wr(ga(24), 32'hff);
    wr(ga(25), 32'hff);
    wr(st_a, 32'h0);
    run(ins(6'd2, 5'd24, 5'd0, 12'h001), 2);
    rd(ga(25), 32'h0);
    rd(st_a, 32'h03);
    run(ins(6'd7, 5'd24, 5'd0, 12'h001), 2);
    rd(ga(24), 32'hff);
    rd(st_a, 32'h15);
    wr(pc_a, 32'h10);
    run(ins(6'd22, 5'd0, 5'd0, 12'hffe), 2);
    rd(pc_a, 32'h0f);
    run(ins(6'd24, 5'd0, 5'd0, 12'h005), 3);
    rd(pc_a, 32'h15);
    rd(sp_a, 32'h1);
    wr(ga(31), 32'h12);
    wr(ga(30), 32'h34);
    run(ins(6'd23, 5'd0, 5'd0, 12'h000), 2);
    rd(pc_a, 32'h1234);
    run(ins(6'd25, 5'd0, 5'd0, 12'h000), 3);
    rd(sp_a, 32'h2);
    run(ins(6'd26, 5'd0, 5'd0, 12'h000), 4);
    rd(pc_a, 32'h1235);
    run(ins(6'd27, 5'd0, 5'd0, 12'h000), 4);
    rd(pc_a, 32'h10);
    rd(st_a, 32'h95);
    chk({31'h0, gie}, 32'h1);
    wr(st_a, 32'h0);
    wr(ga(1), 32'h5a);
    wr(ga(2), 32'h5a);
    wr(ga(3), 32'h08);
    wr(ga(4), 32'h08);
    sk(ins(6'd28, 5'd1, 5'd2, 12'h0), 2);
    sk(ins(6'd28, 5'd1, 5'd2, 12'h0, 1'b1), 3);
    sk(ins(6'd28, 5'd1, 5'd3, 12'h0), 1);
    sk(ins(6'd33, 5'd3, 5'd3, 12'h0), 2);
    sk(ins(6'd32, 5'd3, 5'd3, 12'h0), 1);
    sk(ins(6'd32, 5'd3, 5'd4, 12'h0, 1'b1), 3);
    wr(ia(5), 32'h04);
    sk(ins(6'd35, 5'd0, 5'd2, 12'h005), 2);
    sk(ins(6'd35, 5'd0, 5'd2, 12'h005, 1'b1), 3);
    sk(ins(6'd34, 5'd0, 5'd2, 12'h005), 1);
    sk(ins(6'd34, 5'd0, 5'd1, 12'h005), 2);
    wr(pc_a, 32'h20);
    run(ins(6'd35, 5'd0, 5'd2, 12'h020), 1);
    rd(pc_a, 32'h21);
    rd(st_a, 32'h100);
    wr(st_a, 32'h101);
    run(ins(6'd36, 5'd0, 5'd0, 12'h003), 2);
    rd(pc_a, 32'h25);
    sk(ins(6'd36, 5'd0, 5'd1, 12'h003), 1);
    fset <= 8'hc0;
    @(posedge clk);
    fset <= 8'h00;
    run(ins(6'd37, 5'd0, 5'd0, 12'h00e), 2);
    run(ins(6'd38, 5'd0, 5'd7, 12'h00e), 2);
    rd(ia(14), 32'h41);
    wr(ia(14), 32'h41);
    rd(ia(14), 32'h01);
    run(ins(6'd37, 5'd0, 5'd1, 12'h01f), 2);
    rd(ia(31), 32'h02);
    run(ins(6'd37, 5'd0, 5'd1, 12'h020), 1);
    rd(st_a, 32'h101);
    give_verdict();
  end
endmodule : ebie_core_tb
